// file: core/rsc_pkg.sv
// Purpose: Constants and types for the reset source combiner.
// Assumes: 50 MHz CLK_I, AXI4-Lite register access, 32-bit data.
// Notes:   Cause bit positions follow the packed order of rsc_cause_t.
// Operation
// RL1: Nine reset sources feed the block: power-on plus eight input sources.
// RL2: System reset output is active whenever any source is active.
// RL3: Reset-affected registers are forced to their reset values during system reset.
// RL4: Retained registers are undefined at power-on and survive all other resets.
// RL5: Each reset sets its own cause bit in the reset cause register.
// RL6: Power-on clears all cause bits except brown-out and power-on, which set.
// RL7: Software can set or clear any cause bit at any time; a clear does not take while that bit's source is still active.
// RL8: Software setting a cause bit only changes status, never resets.
// RL9: Software should clear cause bits after reading them.
// RL10: System reset releases synchronously, only after every source is inactive.
package rsc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0]  CAUSE_OFS  = 4'h0;
  localparam logic [3:0]  STATUS_OFS = 4'h4;
  localparam logic [3:0]  CTRL_OFS   = 4'h8;
  localparam logic [3:0]  RETAIN_OFS = 4'hC;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int          CAUSE_W         = 9;
  localparam int          STAT_RST_BIT    = 0;
  localparam int          STAT_SRC_LSB    = 8;
  localparam int          CTRL_SWRST_BIT  = 0;
  localparam logic [8:0]  CAUSE_POR_VAL   = 9'h003;
  localparam logic [0:0]  CTRL_RST_VAL    = 1'h0;
  localparam int          RELEASE_STAGES  = 2;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Packed MSB first: power_on lands in bit 0, brownout in bit 1
  typedef struct packed {
    logic uninit_wreg_reset;
    logic illegal_opcode_reset;
    logic trap_conflict_reset;
    logic config_mismatch_reset;
    logic watchdog_reset;
    logic software_reset_instr;
    logic external_pin_reset;
    logic brownout_reset;
    logic power_on_reset;
  } rsc_cause_t;

endpackage : rsc_pkg

// file: core/rsc_release.sv
// Purpose: Holds a reset level asserted until its request stays low for a few cycles.
// Assumes: hold_i is synchronous to clk_i.
// Notes:   Asserts asynchronously on arst_n_i, releases only on a clock edge.
module rsc_release #(
  parameter int STAGES = 2
) (
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  input  wire logic hold_i,
  output logic      rst_o
);

  logic [STAGES-1:0] pipe_q;

  // ----------------------------------------------------------------
  // Release pipeline
  // ----------------------------------------------------------------
  // Any request refills the pipe, so release needs STAGES quiet cycles
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pipe_q <= '1;
    end else if (hold_i) begin
      pipe_q <= '1;
    end else begin
      pipe_q <= {pipe_q[STAGES-2:0], 1'b0};
    end
  end

  assign rst_o = pipe_q[STAGES-1];

endmodule : rsc_release

// file: core/rsc_top.sv
// Purpose: Merges reset sources into one system reset and records the reset cause.
// Assumes: Source inputs are active high and synchronous to CLK_I.
// Notes:   ARST_N_I is the power-on reset; the bus slave itself survives system reset.
module rsc_top
  import rsc_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        ARST_N_I,
  input  wire logic        EXTERNAL_PIN_RESET_I,
  input  wire logic        SOFTWARE_RESET_INSTR_I,
  input  wire logic        WATCHDOG_RESET_I,
  input  wire logic        BROWNOUT_RESET_I,
  input  wire logic        CONFIG_MISMATCH_RESET_I,
  input  wire logic        TRAP_CONFLICT_RESET_I,
  input  wire logic        ILLEGAL_OPCODE_RESET_I,
  input  wire logic        UNINIT_WREG_RESET_I,
  output logic             SYSTEM_RESET_OUT_O,
  input  wire logic [3:0]  AWADDR_I,
  input  wire logic        AWVALID_I,
  output logic             AWREADY_O,
  input  wire logic [31:0] WDATA_I,
  input  wire logic [3:0]  WSTRB_I,
  input  wire logic        WVALID_I,
  output logic             WREADY_O,
  output logic [1:0]       BRESP_O,
  output logic             BVALID_O,
  input  wire logic        BREADY_I,
  input  wire logic [3:0]  ARADDR_I,
  input  wire logic        ARVALID_I,
  output logic             ARREADY_O,
  output logic [31:0]      RDATA_O,
  output logic [1:0]       RRESP_O,
  output logic             RVALID_O,
  input  wire logic        RREADY_I
);

  rsc_cause_t  live_src;
  rsc_cause_t  cause_q;
  rsc_cause_t  cause_d;
  logic        any_src;
  logic        sys_rst;
  logic [0:0]  ctrl_q;
  logic [31:0] retain_q;

  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;
  logic        aw_held_q;
  logic        w_held_q;
  logic [3:0]  waddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_go;
  logic        wr_cause;
  logic        wr_ctrl;
  logic        wr_retain;
  logic        wr_hit;

  // ----------------------------------------------------------------
  // Source merge
  // ----------------------------------------------------------------
  // Power-on comes in through ARST_N_I, so its live bit is never seen here
  always_comb begin
    live_src                       = '0;
    live_src.external_pin_reset    = EXTERNAL_PIN_RESET_I;    // [RL1]
    live_src.software_reset_instr  = SOFTWARE_RESET_INSTR_I | ctrl_q[CTRL_SWRST_BIT]; // [RL1]
    live_src.watchdog_reset        = WATCHDOG_RESET_I;        // [RL1]
    live_src.brownout_reset        = BROWNOUT_RESET_I;        // [RL1]
    live_src.config_mismatch_reset = CONFIG_MISMATCH_RESET_I; // [RL1]
    live_src.trap_conflict_reset   = TRAP_CONFLICT_RESET_I;   // [RL1]
    live_src.illegal_opcode_reset  = ILLEGAL_OPCODE_RESET_I;  // [RL1]
    live_src.uninit_wreg_reset     = UNINIT_WREG_RESET_I;     // [RL1]
  end

  assign any_src = |live_src; // [RL2]

  // Stretcher refills on any source and drops only after quiet cycles
  rsc_release #(
    .STAGES   (RELEASE_STAGES)
  ) u_release (
    .clk_i    (CLK_I),
    .arst_n_i (ARST_N_I),
    .hold_i   (any_src),  // [RL2] [RL10]
    .rst_o    (sys_rst)
  );

  assign SYSTEM_RESET_OUT_O = sys_rst;

  // ----------------------------------------------------------------
  // Write channel capture
  // ----------------------------------------------------------------
  assign wr_go     = aw_held_q && w_held_q && !bvalid_q;
  assign wr_cause  = wr_go && (waddr_q == CAUSE_OFS);
  assign wr_ctrl   = wr_go && (waddr_q == CTRL_OFS);
  assign wr_retain = wr_go && (waddr_q == RETAIN_OFS);
  assign wr_hit    = wr_cause || wr_ctrl || wr_retain || (waddr_q == STATUS_OFS);

  // Address and data are taken in either order; each ready drops once taken
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      awready_q <= 1'b1;
      aw_held_q <= 1'b0;
      waddr_q   <= 4'h0;
    end else if (AWVALID_I && awready_q) begin
      awready_q <= 1'b0;
      aw_held_q <= 1'b1;
      waddr_q   <= {AWADDR_I[3:2], 2'b00};
    end else if (wr_go) begin
      aw_held_q <= 1'b0;
    end else if (bvalid_q && BREADY_I) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      wready_q <= 1'b1;
      w_held_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (WVALID_I && wready_q) begin
      wready_q <= 1'b0;
      w_held_q <= 1'b1;
      wdata_q  <= WDATA_I;
      wstrb_q  <= WSTRB_I;
    end else if (wr_go) begin
      w_held_q <= 1'b0;
    end else if (bvalid_q && BREADY_I) begin
      wready_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Write response
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && BREADY_I) begin
      bvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Reset cause register
  // ----------------------------------------------------------------
  // A live source wins over a software clear in the same cycle
  always_comb begin
    cause_d = cause_q;
    if (wr_cause && wstrb_q[0]) begin
      cause_d[7:0] = wdata_q[7:0]; // [RL7] [RL8]
    end
    if (wr_cause && wstrb_q[1]) begin
      cause_d[8] = wdata_q[8]; // [RL7] [RL8]
    end
    cause_d = cause_d | live_src; // [RL5]
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      cause_q <= CAUSE_POR_VAL; // [RL6]
    end else begin
      cause_q <= cause_d;
    end
  end

  // ----------------------------------------------------------------
  // Control register, reset-affected
  // ----------------------------------------------------------------
  // Writing the trigger raises the instruction source; the reset it
  // causes forces the bit back, so the request clears itself
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ctrl_q <= CTRL_RST_VAL;
    end else if (sys_rst) begin
      ctrl_q <= CTRL_RST_VAL; // [RL3]
    end else if (wr_ctrl && wstrb_q[0]) begin
      ctrl_q[0] <= wdata_q[CTRL_SWRST_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Retained scratch register
  // ----------------------------------------------------------------
  // No reset on purpose: contents are undefined after power-up and
  // carried unchanged through every system reset
  always_ff @(posedge CLK_I) begin
    for (int b = 0; b < 4; b++) begin
      if (wr_retain && wstrb_q[b]) begin
        retain_q[b*8 +: 8] <= wdata_q[b*8 +: 8]; // [RL4]
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
    end else if (ARVALID_I && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
      unique case ({ARADDR_I[3:2], 2'b00})
        CAUSE_OFS: begin
          rdata_q[CAUSE_W-1:0] <= cause_q;
        end
        STATUS_OFS: begin
          rdata_q[STAT_RST_BIT]                       <= sys_rst;
          rdata_q[STAT_SRC_LSB +: CAUSE_W]            <= live_src;
        end
        CTRL_OFS: begin
          rdata_q[CTRL_SWRST_BIT] <= ctrl_q[0];
        end
        RETAIN_OFS: begin
          rdata_q <= retain_q;
        end
        default: begin
          rresp_q <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && RREADY_I) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign AWREADY_O = awready_q;
  assign WREADY_O  = wready_q;
  assign BVALID_O  = bvalid_q;
  assign BRESP_O   = bresp_q;
  assign ARREADY_O = arready_q;
  assign RVALID_O  = rvalid_q;
  assign RRESP_O   = rresp_q;
  assign RDATA_O   = rdata_q;

endmodule : rsc_top

// file: dv/rsc_props.sv
// Purpose: Port-level checks on the reset combiner.
// Assumes: One clock domain; ARST_N_I low disables every check.
// Notes:   Cause contents are judged by the bench.
module rsc_props (
  input wire logic       CLK_I,
  input wire logic       ARST_N_I,
  input wire logic       EXTERNAL_PIN_RESET_I,
  input wire logic       SOFTWARE_RESET_INSTR_I,
  input wire logic       WATCHDOG_RESET_I,
  input wire logic       BROWNOUT_RESET_I,
  input wire logic       CONFIG_MISMATCH_RESET_I,
  input wire logic       TRAP_CONFLICT_RESET_I,
  input wire logic       ILLEGAL_OPCODE_RESET_I,
  input wire logic       UNINIT_WREG_RESET_I,
  input wire logic       SYSTEM_RESET_OUT_O,
  input wire logic [3:0] AWADDR_I,
  input wire logic       AWVALID_I,
  input wire logic       AWREADY_O,
  input wire logic       BVALID_O,
  input wire logic       BREADY_I,
  input wire logic       ARVALID_I,
  input wire logic       ARREADY_O,
  input wire logic       RVALID_O
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] src_w;
  assign src_w = {UNINIT_WREG_RESET_I, ILLEGAL_OPCODE_RESET_I, TRAP_CONFLICT_RESET_I,
    CONFIG_MISMATCH_RESET_I, WATCHDOG_RESET_I, SOFTWARE_RESET_INSTR_I,
    EXTERNAL_PIN_RESET_I, BROWNOUT_RESET_I};
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);
  sequence drop_s;
    $fell(|src_w);
  endsequence
  sequence hold_free_s;
    SYSTEM_RESET_OUT_O ##[1:4] !SYSTEM_RESET_OUT_O;
  endsequence
  any_src_a: assert property (|src_w |=> SYSTEM_RESET_OUT_O)
    else $error("reset missing after source");
  por_hold_a: assert property (!$past(ARST_N_I) |-> SYSTEM_RESET_OUT_O)
    else $error("reset low right after power-on");
  rel_quiet_a: assert property ($fell(SYSTEM_RESET_OUT_O) |-> $past(src_w) == 8'h00)
    else $error("reset released with source active");
  rel_bound_a: assert property (drop_s |-> hold_free_s)
    else $error("reset release late or early");
  sw_set_a: assert property (AWVALID_I && AWREADY_O && AWADDR_I == 4'h0 &&
    !SYSTEM_RESET_OUT_O && src_w == 8'h00 |=> !SYSTEM_RESET_OUT_O [*2])
    else $error("cause write caused reset");
  wr_resp_a: assert property (AWVALID_I && AWREADY_O |-> ##[1:4] BVALID_O)
    else $error("write response missing");
  b_once_a: assert property (BVALID_O && BREADY_I |=> !BVALID_O)
    else $error("write response repeated");
  rd_resp_a: assert property (ARVALID_I && ARREADY_O |=> RVALID_O && !ARREADY_O)
    else $error("read response missing");
endmodule : rsc_props

// file: dv/rsc_core_model.sv
// Purpose: Stand-in for the core and peripherals under the system reset.
// Assumes: System reset is an active-high level.
// Notes:   Counts reset episodes for the bench to match.
module rsc_core_model (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  output int        n_rst_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic held = 0;
  initial n_rst_o = 0;
  // Unknown before the first edge still counts the power-on episode
  always @(posedge clk_i) begin
    held <= sys_rst_i;
    if (sys_rst_i === 1'b1 && held !== 1'b1) n_rst_o <= n_rst_o + 1;
  end
endmodule : rsc_core_model

// file: dv/testbench.sv
// Purpose: Self-checking bench for the reset combiner.
// Assumes: One step at a time; each write ends before the next step.
// Notes:   An integer model holds expected cause bits and reset count.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import rsc_pkg::*;
  logic CLK_I = 0, ARST_N_I = 0, AWVALID_I = 0, WVALID_I = 0, BREADY_I = 0;
  logic ARVALID_I = 0, RREADY_I = 0, SYSTEM_RESET_OUT_O, AWREADY_O, WREADY_O;
  logic BVALID_O, ARREADY_O, RVALID_O, EXTERNAL_PIN_RESET_I, SOFTWARE_RESET_INSTR_I;
  logic WATCHDOG_RESET_I, BROWNOUT_RESET_I, CONFIG_MISMATCH_RESET_I, TRAP_CONFLICT_RESET_I;
  logic ILLEGAL_OPCODE_RESET_I, UNINIT_WREG_RESET_I;
  logic [1:0]  BRESP_O, RRESP_O;
  logic [3:0]  AWADDR_I = 0, ARADDR_I = 0, WSTRB_I = 4'hF;
  logic [31:0] WDATA_I = 0, RDATA_O;
  logic [7:0]  src = 0;
  int n_errors = 0, compares = 0, n_seen, exp_cause, exp_rst = 1, i, v;
  int unsigned kept[$];
  assign {UNINIT_WREG_RESET_I, ILLEGAL_OPCODE_RESET_I, TRAP_CONFLICT_RESET_I,
    CONFIG_MISMATCH_RESET_I, WATCHDOG_RESET_I, SOFTWARE_RESET_INSTR_I,
    EXTERNAL_PIN_RESET_I, BROWNOUT_RESET_I} = src;
  rsc_top i_rsc_top (
    .CLK_I                  (CLK_I),
    .ARST_N_I               (ARST_N_I),
    .EXTERNAL_PIN_RESET_I   (EXTERNAL_PIN_RESET_I),
    .SOFTWARE_RESET_INSTR_I (SOFTWARE_RESET_INSTR_I),
    .WATCHDOG_RESET_I       (WATCHDOG_RESET_I),
    .BROWNOUT_RESET_I       (BROWNOUT_RESET_I),
    .CONFIG_MISMATCH_RESET_I(CONFIG_MISMATCH_RESET_I),
    .TRAP_CONFLICT_RESET_I  (TRAP_CONFLICT_RESET_I),
    .ILLEGAL_OPCODE_RESET_I (ILLEGAL_OPCODE_RESET_I),
    .UNINIT_WREG_RESET_I    (UNINIT_WREG_RESET_I),
    .SYSTEM_RESET_OUT_O     (SYSTEM_RESET_OUT_O),
    .AWADDR_I (AWADDR_I), .AWVALID_I (AWVALID_I), .AWREADY_O (AWREADY_O),
    .WDATA_I  (WDATA_I),  .WSTRB_I   (WSTRB_I),   .WVALID_I  (WVALID_I),  .WREADY_O (WREADY_O),
    .BRESP_O  (BRESP_O),  .BVALID_O  (BVALID_O),  .BREADY_I  (BREADY_I),
    .ARADDR_I (ARADDR_I), .ARVALID_I (ARVALID_I), .ARREADY_O (ARREADY_O),
    .RDATA_O  (RDATA_O),  .RRESP_O   (RRESP_O),   .RVALID_O  (RVALID_O),  .RREADY_I (RREADY_I)
  );
  rsc_core_model i_rsc_core_model (.clk_i(CLK_I), .sys_rst_i(SYSTEM_RESET_OUT_O),
    .n_rst_o(n_seen));
  always #10 CLK_I = ~CLK_I;
  task automatic tally_and_finish;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h not %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tmo;
    n_errors++;
    tally_and_finish;
  endtask : tmo
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK_I);
    AWADDR_I <= a;
    WDATA_I <= d;
    AWVALID_I <= 1;
    WVALID_I <= 1;
    BREADY_I <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge CLK_I);
      if (AWREADY_O) AWVALID_I <= 0;
      if (WREADY_O) WVALID_I <= 0;
      if (BVALID_O) break;
    end
    BREADY_I <= 0;
    if (n == 50) tmo;
    chk(32'(BRESP_O), 32'(RESP_OKAY));
  endtask : wr
  task automatic rc(input logic [3:0] a, input logic [31:0] e);
    int n;
    @(posedge CLK_I);
    ARADDR_I <= a;
    ARVALID_I <= 1;
    RREADY_I <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge CLK_I);
      if (ARREADY_O) ARVALID_I <= 0;
      if (RVALID_O) break;
    end
    RREADY_I <= 0;
    if (n == 50) tmo;
    chk(32'(RRESP_O), 32'(RESP_OKAY));
    chk(RDATA_O, e);
  endtask : rc
  task automatic wt(input logic lv);
    int n;
    for (n = 0; n < 20 && SYSTEM_RESET_OUT_O !== lv; n++) @(posedge CLK_I);
    if (n == 20) tmo;
  endtask : wt
  initial begin
    v = $urandom(82448);
    repeat (3) @(posedge CLK_I);
    chk(SYSTEM_RESET_OUT_O, 1);
    ARST_N_I <= 1;
    rc(CAUSE_OFS, 32'h003);
    wt(0);
    kept.push_back($urandom);
    wr(RETAIN_OFS, kept[0]);
    wr(CAUSE_OFS, 0);
    exp_cause = 0;
    for (i = 0; i < 10; i++) begin
      v = (i < 8) ? (1 << i) : $urandom_range(255, 1);
      @(posedge CLK_I);
      src <= v[7:0];
      repeat (2) @(posedge CLK_I);
      chk(SYSTEM_RESET_OUT_O, 1);
      rc(STATUS_OFS, 32'((v << (STAT_SRC_LSB + 1)) | (1 << STAT_RST_BIT)));
      src <= 0;
      exp_rst++;
      exp_cause = exp_cause | (v << 1);
      wt(0);
      rc(CAUSE_OFS, 32'(exp_cause));
      rc(RETAIN_OFS, kept[0]);
      wr(CAUSE_OFS, 0);
      exp_cause = 0;
    end
    wr(CAUSE_OFS, 32'h1FF);
    repeat (4) @(posedge CLK_I);
    chk(SYSTEM_RESET_OUT_O, 0);
    rc(CAUSE_OFS, 32'h1FF);
    rc(STATUS_OFS, 0);
    wr(CTRL_OFS, 1);
    wt(1);
    exp_rst++;
    wt(0);
    rc(CTRL_OFS, 0);
    @(posedge CLK_I);
    ARST_N_I <= 0;
    exp_rst++;
    repeat (3) @(posedge CLK_I);
    ARST_N_I <= 1;
    rc(CAUSE_OFS, 32'h003);
    wt(0);
    chk(32'(n_seen), 32'(exp_rst));
    tally_and_finish;
  end
endmodule : testbench
bind rsc_top rsc_props i_rsc_props (
  .CLK_I                  (CLK_I),
  .ARST_N_I               (ARST_N_I),
  .EXTERNAL_PIN_RESET_I   (EXTERNAL_PIN_RESET_I),
  .SOFTWARE_RESET_INSTR_I (SOFTWARE_RESET_INSTR_I),
  .WATCHDOG_RESET_I       (WATCHDOG_RESET_I),
  .BROWNOUT_RESET_I       (BROWNOUT_RESET_I),
  .CONFIG_MISMATCH_RESET_I(CONFIG_MISMATCH_RESET_I),
  .TRAP_CONFLICT_RESET_I  (TRAP_CONFLICT_RESET_I),
  .ILLEGAL_OPCODE_RESET_I (ILLEGAL_OPCODE_RESET_I),
  .UNINIT_WREG_RESET_I    (UNINIT_WREG_RESET_I),
  .SYSTEM_RESET_OUT_O     (SYSTEM_RESET_OUT_O),
  .AWADDR_I (AWADDR_I), .AWVALID_I (AWVALID_I), .AWREADY_O (AWREADY_O),
  .BVALID_O (BVALID_O), .BREADY_I  (BREADY_I),
  .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .RVALID_O  (RVALID_O)
);
